/* File: design/bcrb_pkg.sv */
// shared constants for the bridge channel register bank
package bcrb_pkg;

    localparam int          BCRB_NSLOT  = 32;
    localparam int          BCRB_SLOT_W = 5;

    // request kinds on the vendor control port
    localparam logic [2:0]  BCRB_KIND_REG_WR  = 3'h0; // vendor_register_write
    localparam logic [2:0]  BCRB_KIND_REG_RD  = 3'h1; // vendor_register_read
    localparam logic [2:0]  BCRB_KIND_REV_RD  = 3'h2; // revision_read_request
    localparam logic [2:0]  BCRB_KIND_STAT_RD = 3'h3; // bus_status_access_request
    localparam logic [2:0]  BCRB_KIND_STAT_WR = 3'h4; // bus_status_access_request

    // offsets reached only by the dedicated requests
    localparam logic [9:0]  BCRB_REV_ADDR  = 10'h260;
    localparam logic [9:0]  BCRB_STAT_ADDR = 10'h262;
    localparam logic [15:0] BCRB_STAT_MASK = 16'h3f3f;
    localparam logic [15:0] BCRB_STAT_RST  = 16'h0000;

    // slot numbers of registers with special behaviour
    localparam logic [4:0]  BCRB_S_ENABLE = 5'h00;
    localparam logic [4:0]  BCRB_S_FLOW   = 5'h01;
    localparam logic [4:0]  BCRB_S_XON    = 5'h02;
    localparam logic [4:0]  BCRB_S_XOFF   = 5'h03;
    localparam logic [4:0]  BCRB_S_ERR    = 5'h04;
    localparam logic [4:0]  BCRB_S_BRK    = 5'h05;
    localparam logic [4:0]  BCRB_S_GDIR   = 5'h08;
    localparam logic [4:0]  BCRB_S_GSET   = 5'h09;
    localparam logic [4:0]  BCRB_S_GCLR   = 5'h0a;
    localparam logic [4:0]  BCRB_S_GLVL   = 5'h0b;
    localparam logic [4:0]  BCRB_S_OCLK   = 5'h13;
    localparam logic [4:0]  BCRB_S_TXFL   = 5'h15;
    localparam logic [4:0]  BCRB_S_TXCNT  = 5'h16;
    localparam logic [4:0]  BCRB_S_RXFL   = 5'h18;
    localparam logic [4:0]  BCRB_S_RXCNT  = 5'h19;
    localparam logic [4:0]  BCRB_S_THR    = 5'h1c;

    // offsets of the general register slots
    localparam logic [9:0] BCRB_ADDR [BCRB_NSLOT] = '{
        10'h000, 10'h006, 10'h007, 10'h008, 10'h009, 10'h00a, 10'h00b,
        10'h00c, 10'h00d, 10'h00e, 10'h00f, 10'h010, 10'h011, 10'h012,
        10'h013, 10'h014, 10'h015, 10'h016, 10'h017, 10'h018, 10'h01f,
        10'h040, 10'h041, 10'h042, 10'h043, 10'h044, 10'h045, 10'h046,
        10'h047, 10'h060, 10'h06a, 10'h06b};

    // implemented bits that are stored; zero means nothing is stored
    localparam logic [15:0] BCRB_MASK [BCRB_NSLOT] = '{
        16'h0003, 16'h000f, 16'h00ff, 16'h00ff, 16'h0000, 16'hffff,
        16'h000f, 16'h03ff, 16'h03ff, 16'h0000, 16'h0000, 16'h0000,
        16'h07ff, 16'h0003, 16'h0bff, 16'h07ff, 16'h07ff, 16'h0007,
        16'h0007, 16'hffff, 16'h000c, 16'h0006, 16'h0000, 16'h0001,
        16'h0006, 16'h0000, 16'h0001, 16'h0001, 16'h03ff, 16'h0001,
        16'h3ccf, 16'hbccf};

    // reset values, resume and pause characters are not zero
    localparam logic [15:0] BCRB_RST [BCRB_NSLOT] = '{
        16'h0000, 16'h0000, 16'h0011, 16'h0013, 16'h0000, 16'h0000,
        16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
        16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
        16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
        16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
        16'h0000, 16'h0000};

    // field positions
    localparam int          BCRB_EN_TX_BIT    = 0;
    localparam int          BCRB_EN_RX_BIT    = 1;
    localparam int          BCRB_FLOW_HALF    = 3;
    localparam int          BCRB_FLUSH_BIT    = 0;
    localparam int          BCRB_PIN_W        = 10;
    localparam int          BCRB_CNT_W        = 10;
    localparam int          BCRB_NFLAG        = 4;

    // flow mode codes, 101 to 111 act as no flow control
    localparam logic [2:0]  BCRB_FLOW_NONE    = 3'h0;
    localparam logic [2:0]  BCRB_FLOW_HW      = 3'h1;
    localparam logic [2:0]  BCRB_FLOW_SW      = 3'h2;
    localparam logic [2:0]  BCRB_FLOW_ADDR_RX = 3'h3;
    localparam logic [2:0]  BCRB_FLOW_ADDR_TR = 3'h4;

endpackage

/* File: design/bcrb_flag_if.sv */
// carrier between the register bank and its sticky error flags
`timescale 1ns/1ns
interface bcrb_flag_if;
    logic [3:0] set;   // event pulses: overrun, parity, framing, break
    logic       clr;   // read of the line error register
    logic [3:0] flags; // accumulated flags

    modport owner (input set, input clr, output flags);
    modport user  (output set, output clr, input flags);
endinterface

/* File: design/bcrb_sticky_flags.sv */
// read-clear flags that accumulate line error events
`timescale 1ns/1ns
module bcrb_sticky_flags (
    input  wire logic     i_clk_sys,
    input  wire logic     i_rst,
    bcrb_flag_if.owner    flg
);

    logic [3:0] flags_q;
    logic [3:0] flags_d;

    // set wins over the read clear so no event is lost
    assign flags_d   = (flg.clr ? 4'h0 : flags_q) | flg.set; // see RL11
    assign flg.flags = flags_q;

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            flags_q <= 4'h0;
        end else begin
            flags_q <= flags_d;
        end
    end

    set_kept_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (flg.set != 4'h0) |=> ((flags_q & $past(flg.set)) == $past(flg.set)))
        else $error("flag event lost"); // see RL11

endmodule

/* File: design/bcrb_channel_regs.sv */
// register bank of one bridge channel behind the vendor control requests
//
// Contract
// RL1 - every bank register is written and read by the vendor register requests
// RL2 - revision and bus status only through their dedicated requests
// RL3 - each register is 16 bits and every access moves 16 bits
// RL4 - upper byte of byte registers and zero-marked bits are reserved
// RL5 - host writes zero to reserved bits on every modification
// RL6 - host disables the channel before writing most registers
// RL7 - host re-enables the channel after such writes
// RL8 - enable bit 1 is receiver, bit 0 transmitter, both reset low
// RL9 - flow mode: none, hardware, software, address rx, address rx+tx
// RL10 - half-duplex bit 3 makes receiver ignore data while transmitting
// RL11 - error flags accumulate, clear on read; break status is live
// RL12 - reserved bits read zero and writes to them do nothing
`timescale 1ns/1ns
module bcrb_channel_regs #(
    parameter logic [15:0] REVISION = 16'h0001 // arbitrary value
) (
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst,
    input  wire logic        i_req_valid,
    input  wire logic [2:0]  i_req_kind,
    input  wire logic [9:0]  i_req_addr,
    input  wire logic [15:0] i_req_wdata,
    output logic             o_req_done,
    output logic             o_req_refused,
    output logic [15:0]      o_req_rdata,
    input  wire logic        i_tx_active,
    input  wire logic        i_break_live,
    input  wire logic        i_err_overrun,
    input  wire logic        i_err_parity,
    input  wire logic        i_err_framing,
    input  wire logic        i_err_break,
    input  wire logic [11:0] i_pin_state,
    input  wire logic [9:0]  i_txq_level,
    input  wire logic [9:0]  i_rxq_level,
    output logic             o_tx_enable,
    output logic             o_rx_enable,
    output logic             o_rx_accept,
    output logic [2:0]       o_flow_mode,
    output logic             o_half_duplex,
    output logic             o_flow_hw,
    output logic             o_flow_sw,
    output logic             o_addr_match_rx,
    output logic             o_addr_match_tx,
    output logic [7:0]       o_resume_char,
    output logic [7:0]       o_pause_char,
    output logic [15:0]      o_break_len,
    output logic [9:0]       o_pin_out,
    output logic [9:0]       o_pin_dir,
    output logic [15:0]      o_clk_div,
    output logic             o_txq_flush,
    output logic             o_rxq_flush,
    output logic [9:0]       o_rxq_threshold,
    output logic [15:0]      o_bus_status
);

    localparam int NSLOT = bcrb_pkg::BCRB_NSLOT;

    ////////////////////////////////////////////////////////////////////////
    // request decode

    logic [NSLOT-1:0]  hit;
    logic [4:0]        slot;
    logic              mapped;
    logic              is_gen_wr;
    logic              is_gen_rd;
    logic              gen_wr;
    logic              gen_rd;
    logic              rev_ok;
    logic              stat_rd;
    logic              stat_wr;
    logic              accepted;

    // one compare per general slot
    for (genvar g = 0; g < NSLOT; g++) begin : g_hit
        assign hit[g] = (i_req_addr == bcrb_pkg::BCRB_ADDR[g]);
    end

    function automatic logic [4:0] slot_of(input logic [NSLOT-1:0] h);
        logic [4:0] s;
        s = 5'h00;
        for (int k = 0; k < NSLOT; k++) begin
            if (h[k]) begin
                s = 5'(k);
            end
        end
        return s;
    endfunction

    // revision and bus status are not in the general map, so the general
    // requests find them unmapped and are refused
    assign slot      = slot_of(hit);
    assign mapped    = |hit;
    assign is_gen_wr = (i_req_kind == bcrb_pkg::BCRB_KIND_REG_WR);
    assign is_gen_rd = (i_req_kind == bcrb_pkg::BCRB_KIND_REG_RD);
    assign gen_wr    = i_req_valid & is_gen_wr & mapped; // see RL1
    assign gen_rd    = i_req_valid & is_gen_rd & mapped; // see RL1
    assign rev_ok    = i_req_valid
                     & (i_req_kind == bcrb_pkg::BCRB_KIND_REV_RD)
                     & (i_req_addr == bcrb_pkg::BCRB_REV_ADDR); // see RL2
    assign stat_rd   = i_req_valid
                     & (i_req_kind == bcrb_pkg::BCRB_KIND_STAT_RD)
                     & (i_req_addr == bcrb_pkg::BCRB_STAT_ADDR); // see RL2
    assign stat_wr   = i_req_valid
                     & (i_req_kind == bcrb_pkg::BCRB_KIND_STAT_WR)
                     & (i_req_addr == bcrb_pkg::BCRB_STAT_ADDR); // see RL2
    assign accepted  = gen_wr | gen_rd | rev_ok | stat_rd | stat_wr;

    ////////////////////////////////////////////////////////////////////////
    // stored registers

    logic [15:0] cfg_q [NSLOT];
    logic [15:0] stat_q;
    logic [9:0]  pin_out_q;
    logic [9:0]  pin_set;
    logic [9:0]  pin_clr;
    logic        txq_flush_q;
    logic        rxq_flush_q;

    // only implemented bits are kept, so reserved writes have no effect
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            for (int k = 0; k < NSLOT; k++) begin
                cfg_q[k] <= bcrb_pkg::BCRB_RST[k]; // see RL8
            end
        end else if (gen_wr) begin
            cfg_q[slot] <= i_req_wdata & bcrb_pkg::BCRB_MASK[slot]; // see RL12
        end
    end

    // bus status word, reached by its own requests only
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            stat_q <= bcrb_pkg::BCRB_STAT_RST;
        end else if (stat_wr) begin
            stat_q <= i_req_wdata & bcrb_pkg::BCRB_STAT_MASK; // see RL2
        end
    end

    // pin output latch: set and clear may be written with the channel on
    assign pin_set = (gen_wr && slot == bcrb_pkg::BCRB_S_GSET)
                   ? i_req_wdata[9:0] : 10'h000;
    assign pin_clr = (gen_wr && slot == bcrb_pkg::BCRB_S_GCLR)
                   ? i_req_wdata[9:0] : 10'h000;

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            pin_out_q <= 10'h000;
        end else begin
            pin_out_q <= (pin_out_q | pin_set) & ~pin_clr;
        end
    end

    // queue flush is a one-cycle pulse, the written bit is not stored in its slot
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            txq_flush_q <= 1'b0;
            rxq_flush_q <= 1'b0;
        end else begin
            txq_flush_q <= gen_wr && slot == bcrb_pkg::BCRB_S_TXFL
                        && i_req_wdata[bcrb_pkg::BCRB_FLUSH_BIT];
            rxq_flush_q <= gen_wr && slot == bcrb_pkg::BCRB_S_RXFL
                        && i_req_wdata[bcrb_pkg::BCRB_FLUSH_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // line error flags

    bcrb_flag_if flg ();

    assign flg.set = {i_err_overrun, i_err_parity, i_err_framing, i_err_break};
    assign flg.clr = gen_rd && slot == bcrb_pkg::BCRB_S_ERR; // see RL11

    bcrb_sticky_flags u_flags (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .flg       (flg.owner)
    );

    ////////////////////////////////////////////////////////////////////////
    // read data

    logic [15:0] gen_word;
    logic [15:0] rd_word;
    logic [15:0] rdata_q;
    logic        done_q;
    logic        refused_q;

    // live sources replace stored words; every word is a full 16 bits
    always_comb begin
        case (slot)
            bcrb_pkg::BCRB_S_ERR:
                gen_word = {8'h00, i_break_live, flg.flags, 3'h0}; // see RL11
            bcrb_pkg::BCRB_S_GLVL:
                gen_word = {4'h0, i_pin_state};
            bcrb_pkg::BCRB_S_TXCNT:
                gen_word = {6'h00, i_txq_level};
            bcrb_pkg::BCRB_S_RXCNT:
                gen_word = {6'h00, i_rxq_level};
            default:
                gen_word = cfg_q[slot] & bcrb_pkg::BCRB_MASK[slot]; // see RL4
        endcase
    end

    // refused and write requests answer with zero data
    assign rd_word = gen_rd  ? gen_word :
                     rev_ok  ? REVISION :
                     stat_rd ? stat_q   : 16'h0000; // see RL3

    // every request is answered one cycle later
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            done_q    <= 1'b0;
            refused_q <= 1'b0;
            rdata_q   <= 16'h0000;
        end else begin
            done_q    <= i_req_valid;
            refused_q <= i_req_valid & ~accepted;
            rdata_q   <= i_req_valid ? rd_word : 16'h0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs to the serial engine, pins and queues

    logic [2:0] mode;

    assign mode            = cfg_q[bcrb_pkg::BCRB_S_FLOW][2:0];
    assign o_req_done      = done_q;
    assign o_req_refused   = refused_q;
    assign o_req_rdata     = rdata_q;
    assign o_tx_enable     = cfg_q[0][bcrb_pkg::BCRB_EN_TX_BIT]; // see RL8
    assign o_rx_enable     = cfg_q[0][bcrb_pkg::BCRB_EN_RX_BIT]; // see RL8
    assign o_half_duplex   = cfg_q[1][bcrb_pkg::BCRB_FLOW_HALF];
    // half-duplex receiver is deaf while the transmitter runs
    assign o_rx_accept     = o_rx_enable
                           & ~(o_half_duplex & i_tx_active); // see RL10
    assign o_flow_mode     = mode;
    // reserved codes fall through to no flow control
    assign o_flow_hw       = (mode == bcrb_pkg::BCRB_FLOW_HW); // see RL9
    assign o_flow_sw       = (mode == bcrb_pkg::BCRB_FLOW_SW); // see RL9
    assign o_addr_match_rx = (mode == bcrb_pkg::BCRB_FLOW_ADDR_RX)
                           | (mode == bcrb_pkg::BCRB_FLOW_ADDR_TR); // see RL9
    assign o_addr_match_tx = (mode == bcrb_pkg::BCRB_FLOW_ADDR_TR); // see RL9
    assign o_resume_char   = cfg_q[bcrb_pkg::BCRB_S_XON][7:0];
    assign o_pause_char    = cfg_q[bcrb_pkg::BCRB_S_XOFF][7:0];
    assign o_break_len     = cfg_q[bcrb_pkg::BCRB_S_BRK];
    assign o_pin_out       = pin_out_q;
    assign o_pin_dir       = cfg_q[bcrb_pkg::BCRB_S_GDIR][9:0];
    assign o_clk_div       = cfg_q[bcrb_pkg::BCRB_S_OCLK];
    assign o_txq_flush     = txq_flush_q;
    assign o_rxq_flush     = rxq_flush_q;
    assign o_rxq_threshold = cfg_q[bcrb_pkg::BCRB_S_THR][9:0];
    assign o_bus_status    = stat_q;

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    answer_next_a: assert property (i_req_valid |=> o_req_done) // see RL1
        else $error("request not answered next cycle");

    rev_only_a: assert property ( // see RL2
        i_req_valid && is_gen_rd && i_req_addr == bcrb_pkg::BCRB_REV_ADDR
        |=> o_req_refused && o_req_rdata == 16'h0000)
        else $error("revision reached by general read");

    rev_value_a: assert property (rev_ok |=> o_req_rdata == REVISION) // see RL2
        else $error("revision read wrong");

    full_word_a: assert property ( // see RL3
        gen_wr && slot == bcrb_pkg::BCRB_S_BRK
        |=> o_break_len == $past(i_req_wdata))
        else $error("break length not full word");

    upper_zero_a: assert property ( // see RL4
        gen_rd && slot == bcrb_pkg::BCRB_S_XON |=> o_req_rdata[15:8] == 8'h00)
        else $error("reserved byte not zero");

    enable_reset_a: assert property (disable iff (1'b0) // see RL8
        $past(i_rst) |-> !o_tx_enable && !o_rx_enable)
        else $error("enable not cleared by reset");

    mode_decode_a: assert property ( // see RL9
        mode > bcrb_pkg::BCRB_FLOW_ADDR_TR
        |-> !(o_flow_hw || o_flow_sw || o_addr_match_rx || o_addr_match_tx))
        else $error("reserved flow code active");

    half_deaf_a: assert property ( // see RL10
        o_half_duplex && i_tx_active |-> !o_rx_accept)
        else $error("receiver open during half-duplex send");

    err_clear_a: assert property ( // see RL11
        flg.clr && flg.set == 4'h0 ##1 flg.set == 4'h0 |=> flg.flags == 4'h0)
        else $error("error flags not cleared by read");

    break_live_a: assert property ( // see RL11
        flg.clr |=> o_req_rdata[7] == $past(i_break_live))
        else $error("break status not live");

    reserved_wr_a: assert property ( // see RL12
        gen_wr && slot == bcrb_pkg::BCRB_S_ENABLE
        |=> cfg_q[0][15:2] == 14'h0000)
        else $error("reserved enable bits stored");

    cov_gen_write: cover property (gen_wr ##1 o_req_done);
    cov_err_read: cover property (flg.clr ##1 o_req_rdata[6:4] != 3'h0);
    cov_stat_write: cover property (stat_wr ##2 stat_rd);
    cov_refused: cover property (o_req_refused);

endmodule

/* File: testbench/bcrb_host_model.sv */
// bus host model that issues vendor control requests to the bank
`timescale 1ns/1ns
module bcrb_host_model (
    input  wire logic   i_clk_sys,
    output logic        o_req_valid,
    output logic [2:0]  o_req_kind,
    output logic [9:0]  o_req_addr,
    output logic [15:0] o_req_wdata
);
    logic [16:0] exp_q [$]; // {refused, rdata} noted per request

    initial begin
        o_req_valid = 1'b0;
        o_req_kind  = 3'h0;
        o_req_addr  = 10'h000;
        o_req_wdata = 16'h0000;
    end

    ////////////////////////////////////////////////////////////////////
    // raised just after an edge, held over the taking edge, then dropped
    task automatic req(input logic [2:0] kind, input logic [9:0] addr,
                       input logic [15:0] wd, input logic [16:0] exp);
        @(posedge i_clk_sys);
        #1;
        exp_q.push_back(exp);
        o_req_valid = 1'b1;
        o_req_kind  = kind;
        o_req_addr  = addr;
        o_req_wdata = wd;
        @(posedge i_clk_sys);
        #1;
        o_req_valid = 1'b0;
        o_req_wdata = ~wd; // stale data must never look current
    endtask

    // ordinary write, reserved bits cleared by the keep mask
    task automatic wr_reg(input logic [9:0] addr, input logic [15:0] d,
                          input logic [15:0] keep);
        req(bcrb_pkg::BCRB_KIND_REG_WR, addr, d & keep, 17'h0);
    endtask

    task automatic rd_reg(input logic [9:0] addr, input logic [15:0] exp);
        req(bcrb_pkg::BCRB_KIND_REG_RD, addr, 16'h0, {1'b0, exp});
    endtask

    // channel off before configuration, back on afterwards
    task automatic chan_off();
        wr_reg(10'h000, 16'h0000, 16'h0003);
    endtask

    task automatic chan_on(input logic [15:0] v);
        wr_reg(10'h000, v, 16'h0003);
    endtask
endmodule

/* File: testbench/bridge_channel_register_bank_tb_top.sv */
// self-checking bench for the bridge channel register bank
`timescale 1ns/1ns
module bridge_channel_register_bank_tb_top;
    localparam logic [15:0] REV = 16'h5a3c; // arbitrary revision value
    localparam logic [9:0]  A_FLOW = 10'h006;
    localparam logic [9:0]  A_ERR  = 10'h009;

    logic        clk_sys;
    logic        rst;
    logic        tx_active;
    logic        break_live;
    logic [3:0]  err;       // overrun, parity, framing, break events
    logic [11:0] pin_state;
    logic [9:0]  txq;
    logic [9:0]  rxq;
    logic        req_valid;
    logic [2:0]  req_kind;
    logic [9:0]  req_addr;
    logic [15:0] req_wdata;
    logic        done;
    logic        refused;
    logic [15:0] rdata;
    logic        tx_en;
    logic        rx_en;
    logic        rx_acc;
    logic [2:0]  fmode;
    logic [3:0]  fdec;      // hw, sw, address rx, address tx
    logic [7:0]  resume;
    logic [7:0]  pause;
    logic [9:0]  pin_out;
    logic        hd;
    logic [15:0] brk_len;
    logic [9:0]  pin_dir;
    logic [15:0] clk_div;
    logic        txfl;
    logic        rxfl;
    logic [9:0]  rxthr;
    logic [15:0] bus_stat;
    logic [15:0] wr [bcrb_pkg::BCRB_NSLOT];
    logic [3:0]  f;
    logic [9:0]  a;
    logic [9:0]  b;
    int          n_errors;
    int          compares;

    bcrb_host_model i_host (.i_clk_sys(clk_sys), .o_req_valid(req_valid),
        .o_req_kind(req_kind), .o_req_addr(req_addr),
        .o_req_wdata(req_wdata));

    bcrb_channel_regs #(.REVISION(REV)) i_dut (.i_clk_sys(clk_sys),
        .i_rst(rst), .i_req_valid(req_valid), .i_req_kind(req_kind),
        .i_req_addr(req_addr), .i_req_wdata(req_wdata), .o_req_done(done),
        .o_req_refused(refused), .o_req_rdata(rdata),
        .i_tx_active(tx_active), .i_break_live(break_live),
        .i_err_overrun(err[3]), .i_err_parity(err[2]),
        .i_err_framing(err[1]), .i_err_break(err[0]),
        .i_pin_state(pin_state), .i_txq_level(txq), .i_rxq_level(rxq),
        .o_tx_enable(tx_en), .o_rx_enable(rx_en), .o_rx_accept(rx_acc),
        .o_flow_mode(fmode), .o_half_duplex(hd), .o_flow_hw(fdec[3]),
        .o_flow_sw(fdec[2]), .o_addr_match_rx(fdec[1]),
        .o_addr_match_tx(fdec[0]), .o_resume_char(resume),
        .o_pause_char(pause), .o_break_len(brk_len), .o_pin_out(pin_out),
        .o_pin_dir(pin_dir), .o_clk_div(clk_div), .o_txq_flush(txfl),
        .o_rxq_flush(rxfl), .o_rxq_threshold(rxthr),
        .o_bus_status(bus_stat));

    ////////////////////////////////////////////////////////////////////
    task automatic check(input logic [16:0] seen, input logic [16:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic summarize();
        if (n_errors == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // refused request: no answer data, no state change
    task automatic refuse(input logic [2:0] kind, input logic [9:0] addr);
        i_host.req(kind, addr, 16'hffff, 17'h10000);
    endtask

    // live sources read straight through, stored slots keep masked data
    function automatic logic [15:0] exp_rd(input logic [4:0] s);
        case (s)
            bcrb_pkg::BCRB_S_GLVL:  return {4'h0, pin_state};
            bcrb_pkg::BCRB_S_TXCNT: return {6'h00, txq};
            bcrb_pkg::BCRB_S_RXCNT: return {6'h00, rxq};
            default:                return wr[s] & bcrb_pkg::BCRB_MASK[s];
        endcase
    endfunction

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    // each answer pulse is matched to the oldest note of the host
    always @(negedge clk_sys) begin
        if (done === 1'b1) begin
            if (i_host.exp_q.size() > 0)
                check({refused, rdata}, i_host.exp_q.pop_front());
            else
                check({refused, rdata}, 17'h1ffff);
        end
    end

    initial begin
        n_errors = 0;
        compares = 0;
        rst = 1'b1;
        tx_active = 1'b0;
        break_live = 1'b0;
        err = 4'h0;
        void'($urandom(33104));
        pin_state = 12'($urandom);
        txq = 10'($urandom);
        rxq = 10'($urandom);
        repeat (20) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        check({1'b0, resume, pause}, {1'b0, 8'h11, 8'h13});
        check({15'h0, tx_en, rx_en}, 17'h0);
        // random fill of every slot but the enable with the channel off, then read back
        i_host.chan_off();
        wr[0] = 16'h0000;
        for (int i = 1; i < bcrb_pkg::BCRB_NSLOT; i++) begin
            wr[i] = 16'($urandom);
            i_host.wr_reg(bcrb_pkg::BCRB_ADDR[i], wr[i],
                          bcrb_pkg::BCRB_MASK[i]);
        end
        // stored words drive the engine outputs at full width
        check({1'b0, brk_len}, {1'b0, wr[5]});
        check({1'b0, clk_div}, {1'b0, wr[19]});
        check({6'h0, hd, pin_dir}, {6'h0, wr[1][3], wr[8][9:0]});
        check({7'h0, rxthr}, {7'h0, wr[28][9:0]});
        // flush bit is a one-cycle pulse and reads back as zero
        i_host.wr_reg(10'h040, 16'h0001, 16'h0001);
        check({15'h0, txfl, rxfl}, 17'h00002);
        i_host.wr_reg(10'h043, 16'h0001, 16'h0001);
        check({15'h0, txfl, rxfl}, 17'h00001);
        wr[21] = 16'h0001;
        wr[24] = 16'h0001;
        for (int i = 0; i < bcrb_pkg::BCRB_NSLOT; i++)
            i_host.rd_reg(bcrb_pkg::BCRB_ADDR[i], exp_rd(i[4:0]));
        // every flow code, reserved ones decode to no flow control
        for (int k = 0; k < 8; k++) begin
            i_host.wr_reg(A_FLOW, 16'(k), 16'h000f);
            check({10'h0, fdec, fmode}, {10'h0, k == 1, k == 2,
                  k == 3 || k == 4, k == 4, 3'(k)});
        end
        // half duplex drops receive only while transmitting
        i_host.wr_reg(A_FLOW, 16'h0008, 16'h000f);
        i_host.chan_on(16'h0003);
        tx_active = 1'b1;
        #1;
        check({14'h0, tx_en, rx_en, rx_acc}, 17'h00006);
        @(posedge clk_sys);
        #1;
        tx_active = 1'b0;
        #1;
        check({14'h0, tx_en, rx_en, rx_acc}, 17'h00007);
        // pin set then clear, allowed while the channel runs
        a = 10'($urandom);
        b = 10'($urandom);
        i_host.wr_reg(10'h00e, {6'h00, a}, 16'h03ff);
        i_host.wr_reg(10'h00f, {6'h00, b}, 16'h03ff);
        check({7'h00, pin_out}, {7'h00, a & ~b});
        // error events gather until read; break status follows live input
        f = 4'($urandom) | 4'h1;
        @(posedge clk_sys);
        #1;
        err = f;
        break_live = 1'b1;
        @(posedge clk_sys);
        #1;
        err = 4'h0;
        i_host.rd_reg(A_ERR, {8'h00, 1'b1, f, 3'h0});
        i_host.rd_reg(A_ERR, 16'h0080);
        break_live = 1'b0;
        i_host.rd_reg(A_ERR, 16'h0000);
        // dedicated registers are out of reach of the general requests
        refuse(bcrb_pkg::BCRB_KIND_REG_RD, 10'h260);
        refuse(bcrb_pkg::BCRB_KIND_REG_RD, 10'h262);
        refuse(bcrb_pkg::BCRB_KIND_REG_WR, 10'h262);
        refuse(bcrb_pkg::BCRB_KIND_REG_RD, 10'h001);
        refuse(bcrb_pkg::BCRB_KIND_REV_RD, 10'h000);
        refuse(bcrb_pkg::BCRB_KIND_STAT_RD, 10'h000);
        refuse(3'h7, 10'h000);
        i_host.req(bcrb_pkg::BCRB_KIND_REV_RD, 10'h260, 16'h0,
                   {1'b0, REV});
        i_host.req(bcrb_pkg::BCRB_KIND_STAT_RD, 10'h262, 16'h0, 17'h0);
        i_host.req(bcrb_pkg::BCRB_KIND_STAT_WR, 10'h262, 16'hffff, 17'h0);
        i_host.req(bcrb_pkg::BCRB_KIND_STAT_RD, 10'h262, 16'h0,
                   {1'b0, bcrb_pkg::BCRB_STAT_MASK});
        check({1'b0, bus_stat}, {1'b0, bcrb_pkg::BCRB_STAT_MASK});
        // deliberate write of reserved enable bits
        i_host.wr_reg(10'h000, 16'hfffe, 16'hffff);
        check({15'h0, tx_en, rx_en}, 17'h00001);
        i_host.rd_reg(10'h000, 16'h0002);
        for (int t = 0; t < 20 && i_host.exp_q.size() > 0; t++)
            @(posedge clk_sys);
        if (i_host.exp_q.size() > 0)
            n_errors++;
        summarize();
    end
endmodule
